// file: core/fsi_fault_irq.sv
// What this block does
// R01: Alert line released normally, pulled low on an enabled fault flag.
// R02: Six sources each gated by an enable bit; none enabled after reset.
// R03: Triggered fault sets its flag in the low six status bits.
// R04: Flags: overheat, low input, power-good failure on channels 4 to 1.
// R05: Flag clears by writing 1, all enables low, or power-on reset.
// R06: Reading a flag or writing 0 to it leaves it unchanged.
// R07: Shutdown indication turns all channels off until it falls away.
// R08: Leaving shutdown starts soft-start on each enabled channel.
// R09: Shutdown sets latched bit 4; write 1 clears only when fault gone.
// R10: Overheat threshold selectable among three settings; crossing sets flag.
// R11: Overheat only warns; no channel is disabled.
// R12: Low-input threshold programmable in steps; supply below it sets flag.
// R13: Low-input detection only warns; no channel shuts down.
// R14: Serial interface works up to 400 kHz; controller stays within that.
// R15: General call address is neither acknowledged nor acted on.
// R16: During a read only the starting controller may use the device.
// R17: Device answers the default seven-bit target address.
// R18: Address select input changes the target address for bus sharing.
// R19: Bits taken on clock rise; read data driven on open-drain data line.
// R20: Subaddress follows target address and selects the register accessed.
// R21: Status bits clear on writing 1; no write of 0 needed.
// R22: Power-good drops after 50 us below threshold, raising its fail flag.
// R23: Alert held low while any enabled flag stays set.
// R24: Write and read sequences of the controller are fixed single-byte forms.
module fsi_fault_irq
    import fsi_pkg::*;
(
    // System clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Serial link
    input wire logic link_clk,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n,
    input wire logic address_select,
    // Fault indications
    input wire logic overheat_detect,
    input wire logic channel1_supply_low,
    input wire logic thermal_shutdown_detect,
    input wire logic [3:0] pg_below_fail,
    input wire logic [3:0] pg_above_good,
    input wire logic [3:0] channel_enable_inputs,
    // Alert line
    output logic alert_o,
    output logic alert_oe_n,
    // Channel control and thresholds
    output logic [1:0] overheat_threshold_sel,
    output logic [3:0] low_input_threshold_code,
    output logic [3:0] channel_run,
    output logic [3:0] soft_start_pulse,
    output logic [3:0] channel_power_good
);

    fsi_sys_t s;
    fsi_sys_t next_s;
    fsi_link_t l;
    fsi_link_t next_l;
    fsi_pins_t pins_in;
    logic rst_ff1;
    logic rst_ff2;
    logic lrst_ff1;
    logic lrst_ff2;

    function automatic logic [7:0] fsi_read(input logic [7:0] addr,
                                            input fsi_sys_t st);
        logic [7:0] v;
        v = 8'h00;
        unique case (addr)
            FSI_REG_THRESHOLD_CONFIG: v = st.threshold_config;
            FSI_REG_LATCHED_FAULT_STATUS:
                v[FSI_SHUTDOWN_LATCHED_BIT] = st.shutdown_latched;
            FSI_REG_FAULT_INTERRUPT_STATUS: v[5:0] = st.irq_status;
            FSI_REG_FAULT_INTERRUPT_ENABLE: v[5:0] = st.irq_enable;
            default: v = 8'h00;
        endcase
        return v;
    endfunction : fsi_read

    // Reset release, one synchroniser per domain
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_ff1 <= 1'b0;
            rst_ff2 <= 1'b0;
        end else begin
            rst_ff1 <= 1'b1;
            rst_ff2 <= rst_ff1;
        end
    end

    always_ff @(posedge link_clk or negedge rst_n) begin
        if (!rst_n) begin
            lrst_ff1 <= 1'b0;
            lrst_ff2 <= 1'b0;
        end else begin
            lrst_ff1 <= 1'b1;
            lrst_ff2 <= lrst_ff1;
        end
    end

    always_comb begin
        pins_in.overheat = overheat_detect;
        pins_in.low_input = channel1_supply_low;
        pins_in.shutdown = thermal_shutdown_detect;
        pins_in.pg_below = pg_below_fail;
        pins_in.pg_good = pg_above_good;
        pins_in.en = channel_enable_inputs;
    end

    // System domain: registers, flags, channel control
    always_comb begin
        logic new_req;
        logic [5:0] set_f;
        logic [5:0] clr_f;
        logic clr_sd;
        logic sd;
        next_s = s;
        new_req = 1'b0;
        set_f = 6'h00;
        clr_f = 6'h00;
        clr_sd = 1'b0;
        sd = s.pin_s2.shutdown;
        next_s.pin_s1 = pins_in;
        next_s.pin_s2 = s.pin_s1;
        next_s.rq_s1 = l.req_tgl;
        next_s.rq_s2 = s.rq_s1;
        next_s.rq_s3 = s.rq_s2;
        new_req = s.rq_s2 ^ s.rq_s3;
        // The request bundle is held still by the link until its next byte is received
        if (new_req) begin
            if (l.req.wr) begin
                unique case (l.req.addr) // [R20]
                    FSI_REG_THRESHOLD_CONFIG:
                        next_s.threshold_config = l.req.data; // [R10] [R12]
                    FSI_REG_FAULT_INTERRUPT_ENABLE:
                        next_s.irq_enable = l.req.data[5:0]; // [R02]
                    FSI_REG_FAULT_INTERRUPT_STATUS:
                        clr_f = l.req.data[5:0]; // [R05] [R06] [R21]
                    FSI_REG_LATCHED_FAULT_STATUS:
                        clr_sd = l.req.data[FSI_SHUTDOWN_LATCHED_BIT]
                                 & ~sd; // [R09] [R21]
                    default: ;
                endcase
            end
            next_s.rd_data = fsi_read(l.req.addr, s); // [R20]
            next_s.ack_tgl = ~s.ack_tgl;
        end
        set_f[FSI_FLAG_OVERHEAT] = s.pin_s2.overheat; // [R04] [R10] [R11]
        set_f[FSI_FLAG_LOW_INPUT] = s.pin_s2.low_input; // [R12] [R13]
        // Power-good filter: a short dip below threshold is ignored
        for (int i = 0; i < 4; i++) begin
            if (s.pg[i] && s.pin_s2.pg_below[i]) begin
                if (s.pg_cnt[i] ==
                    FSI_PG_CNT_W'(FSI_PG_FILTER_CYC - 1)) begin
                    next_s.pg[i] = 1'b0; // [R22]
                    next_s.pg_cnt[i] = '0;
                    set_f[FSI_FLAG_CH1_PG + i] = 1'b1; // [R04] [R22]
                end else begin
                    next_s.pg_cnt[i] = s.pg_cnt[i] + 1'b1;
                end
            end else begin
                next_s.pg_cnt[i] = '0;
                if (s.pin_s2.pg_good[i] && !s.pin_s2.pg_below[i]) begin
                    next_s.pg[i] = 1'b1;
                end
            end
        end
        if (s.pin_s2.en == 4'h0) begin
            clr_f = 6'h3F; // [R05]
        end
        // Set wins over a clear in the same cycle
        next_s.irq_status = (s.irq_status & ~clr_f) | set_f; // [R03] [R05]
        next_s.shutdown_latched = (s.shutdown_latched & ~clr_sd) | sd; // [R09]
        next_s.shutdown_prev = sd;
        next_s.run = sd ? 4'h0 : s.pin_s2.en; // [R07] [R11] [R13]
        next_s.soft_start = (s.shutdown_prev && !sd) ?
                            s.pin_s2.en : 4'h0; // [R08]
        next_s.alert_oe_n =
            ~|(next_s.irq_status & next_s.irq_enable); // [R01] [R23]
        next_s.alert_o = 1'b0;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
            s.threshold_config <= FSI_THRESHOLD_CONFIG_RST;
            s.irq_enable <= FSI_ENABLE_RST; // [R02]
            s.irq_status <= FSI_STATUS_RST; // [R05]
            s.alert_oe_n <= 1'b1; // [R01]
        end else if (!rst_ff2) begin
            s <= '0;
            s.threshold_config <= FSI_THRESHOLD_CONFIG_RST;
            s.irq_enable <= FSI_ENABLE_RST;
            s.irq_status <= FSI_STATUS_RST;
            s.alert_oe_n <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    // Link domain: serial target engine
    // Oversampling on link_clk copes with SCL up to the 400 kHz limit
    always_comb begin
        logic scl_rise;
        logic scl_fall;
        logic start_c;
        logic stop_c;
        logic [6:0] own;
        next_l = l;
        scl_rise = 1'b0;
        scl_fall = 1'b0;
        start_c = 1'b0;
        stop_c = 1'b0;
        own = '0;
        next_l.scl_s1 = scl_i;
        next_l.scl_s2 = l.scl_s1;
        next_l.scl_s3 = l.scl_s2;
        next_l.sda_s1 = sda_i;
        next_l.sda_s2 = l.sda_s1;
        next_l.sda_s3 = l.sda_s2;
        next_l.asel_s1 = address_select;
        next_l.asel_s2 = l.asel_s1;
        next_l.ack_s1 = s.ack_tgl;
        next_l.ack_s2 = l.ack_s1;
        next_l.ack_s3 = l.ack_s2;
        next_l.sda_o = 1'b0;
        scl_rise = l.scl_s2 & ~l.scl_s3; // [R14]
        scl_fall = ~l.scl_s2 & l.scl_s3;
        start_c = l.scl_s2 & l.scl_s3 & ~l.sda_s2 & l.sda_s3;
        stop_c = l.scl_s2 & l.scl_s3 & l.sda_s2 & ~l.sda_s3;
        own = {FSI_TARGET_ADDR[6:1], l.asel_s2}; // [R17] [R18]
        if (l.ack_s2 ^ l.ack_s3) begin
            next_l.rdat = s.rd_data;
        end
        if (stop_c) begin
            next_l.state = FSI_IDLE;
            next_l.sda_oe_n = 1'b1;
        // A start seen while the device drives read data is ignored
        end else if (start_c && l.state != FSI_RDAT) begin // [R16]
            next_l.state = FSI_ADDR;
            next_l.bitcnt = 4'h0;
            next_l.sda_oe_n = 1'b1;
        end else begin
            unique case (l.state)
                FSI_IDLE: ;
                FSI_ADDR, FSI_SUB, FSI_WDAT: begin
                    if (scl_rise && l.bitcnt != 4'h8) begin
                        next_l.shreg = {l.shreg[6:0], l.sda_s2}; // [R19]
                        next_l.bitcnt = l.bitcnt + 4'h1;
                    end
                    if (scl_fall && l.bitcnt == 4'h8) begin
                        next_l.bitcnt = 4'h0;
                        next_l.state = FSI_ACK;
                        next_l.sda_oe_n = 1'b0;
                        unique case (l.state)
                            FSI_ADDR: begin
                                if (l.shreg[7:1] == own &&
                                    l.shreg[7:1] != FSI_GENERAL_CALL) begin
                                    next_l.rw = l.shreg[0]; // [R15] [R17]
                                    next_l.after = l.shreg[0] ?
                                                   FSI_RDAT : FSI_SUB;
                                end else begin
                                    next_l.state = FSI_IDLE; // [R15]
                                    next_l.sda_oe_n = 1'b1;
                                end
                            end
                            FSI_SUB: begin
                                next_l.sub = l.shreg; // [R20]
                                next_l.req.wr = 1'b0;
                                next_l.req.addr = l.shreg;
                                next_l.req.data = 8'h00;
                                next_l.req_tgl = ~l.req_tgl;
                                next_l.after = FSI_WDAT;
                            end
                            default: begin
                                next_l.req.wr = 1'b1; // [R20]
                                next_l.req.addr = l.sub;
                                next_l.req.data = l.shreg;
                                next_l.req_tgl = ~l.req_tgl;
                                next_l.after = FSI_WDAT;
                            end
                        endcase
                    end
                end
                FSI_ACK: begin
                    if (scl_fall) begin
                        next_l.state = l.after;
                        if (l.after == FSI_RDAT) begin
                            next_l.tx = l.rdat;
                            next_l.sda_oe_n = l.rdat[7]; // [R19]
                            next_l.bitcnt = 4'h1;
                        end else begin
                            next_l.sda_oe_n = 1'b1;
                            next_l.bitcnt = 4'h0;
                        end
                    end
                end
                FSI_RDAT: begin
                    if (scl_fall) begin
                        if (l.bitcnt == 4'h8) begin
                            next_l.sda_oe_n = 1'b1;
                            next_l.state = FSI_RACK;
                        end else begin
                            next_l.tx = {l.tx[6:0], 1'b0};
                            next_l.sda_oe_n = l.tx[6]; // [R19]
                            next_l.bitcnt = l.bitcnt + 4'h1;
                        end
                    end
                end
                FSI_RACK: begin
                    if (scl_rise) begin
                        next_l.acked = ~l.sda_s2;
                    end
                    if (scl_fall) begin
                        if (l.acked) begin
                            next_l.tx = l.rdat;
                            next_l.sda_oe_n = l.rdat[7];
                            next_l.bitcnt = 4'h1;
                            next_l.state = FSI_RDAT;
                        end else begin
                            next_l.state = FSI_IDLE; // [R16] [R24]
                        end
                    end
                end
                default: begin
                    next_l.state = FSI_IDLE;
                    next_l.sda_oe_n = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge link_clk or negedge rst_n) begin
        if (!rst_n) begin
            l <= '0;
            l.state <= FSI_IDLE;
            l.after <= FSI_IDLE;
            l.scl_s1 <= 1'b1;
            l.scl_s2 <= 1'b1;
            l.scl_s3 <= 1'b1;
            l.sda_s1 <= 1'b1;
            l.sda_s2 <= 1'b1;
            l.sda_s3 <= 1'b1;
            l.sda_oe_n <= 1'b1;
        end else if (!lrst_ff2) begin
            l <= '0;
            l.state <= FSI_IDLE;
            l.after <= FSI_IDLE;
            l.scl_s1 <= 1'b1;
            l.scl_s2 <= 1'b1;
            l.scl_s3 <= 1'b1;
            l.sda_s1 <= 1'b1;
            l.sda_s2 <= 1'b1;
            l.sda_s3 <= 1'b1;
            l.sda_oe_n <= 1'b1;
        end else begin
            l <= next_l;
        end
    end

    assign sda_o = l.sda_o;
    assign sda_oe_n = l.sda_oe_n;
    assign alert_o = s.alert_o;
    assign alert_oe_n = s.alert_oe_n;
    assign overheat_threshold_sel =
        s.threshold_config[FSI_CFG_OVERHEAT_LSB +: 2];
    assign low_input_threshold_code =
        s.threshold_config[FSI_CFG_LOW_INPUT_LSB +: 4];
    assign channel_run = s.run;
    assign soft_start_pulse = s.soft_start;
    assign channel_power_good = s.pg;

endmodule : fsi_fault_irq

// file: core/fsi_pkg.sv
package fsi_pkg;

    // Register subaddresses
    localparam logic [7:0] FSI_REG_THRESHOLD_CONFIG = 8'h09;
    localparam logic [7:0] FSI_REG_LATCHED_FAULT_STATUS = 8'h0C;
    localparam logic [7:0] FSI_REG_FAULT_INTERRUPT_STATUS = 8'h0E;
    localparam logic [7:0] FSI_REG_FAULT_INTERRUPT_ENABLE = 8'h0F;

    // Fault flag positions in status and enable registers
    localparam int FSI_FLAG_CH1_PG = 0;
    localparam int FSI_FLAG_CH2_PG = 1;
    localparam int FSI_FLAG_CH3_PG = 2;
    localparam int FSI_FLAG_CH4_PG = 3;
    localparam int FSI_FLAG_LOW_INPUT = 4;
    localparam int FSI_FLAG_OVERHEAT = 5;
    localparam int FSI_NUM_FLAGS = 6;
    localparam int FSI_SHUTDOWN_LATCHED_BIT = 4;

    // Threshold configuration fields
    localparam int FSI_CFG_LOW_INPUT_LSB = 0;
    localparam int FSI_CFG_OVERHEAT_LSB = 4;

    // Reset values
    localparam logic [7:0] FSI_THRESHOLD_CONFIG_RST = 8'h00;
    localparam logic [5:0] FSI_ENABLE_RST = 6'h00;
    localparam logic [5:0] FSI_STATUS_RST = 6'h00;

    // Serial target addressing
    localparam logic [6:0] FSI_TARGET_ADDR = 7'h48;
    localparam logic [6:0] FSI_GENERAL_CALL = 7'h00;

    // Timing
    localparam int FSI_CLK_HZ = 10_000_000;
    localparam int FSI_SCL_MAX_HZ = 400_000;
    localparam int FSI_PG_FILTER_NS = 50_000;
    localparam int FSI_PG_FILTER_CYC =
        (FSI_PG_FILTER_NS * (FSI_CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int FSI_PG_CNT_W = 9;

    typedef enum logic [2:0] {
        FSI_IDLE = 3'b000,
        FSI_ADDR = 3'b001,
        FSI_SUB = 3'b010,
        FSI_WDAT = 3'b011,
        FSI_ACK = 3'b100,
        FSI_RDAT = 3'b101,
        FSI_RACK = 3'b110
    } fsi_lstate_t;

    typedef struct packed {
        logic overheat;
        logic low_input;
        logic shutdown;
        logic [3:0] pg_below;
        logic [3:0] pg_good;
        logic [3:0] en;
    } fsi_pins_t;

    typedef struct packed {
        logic wr;
        logic [7:0] addr;
        logic [7:0] data;
    } fsi_req_t;

    typedef struct packed {
        fsi_pins_t pin_s1;
        fsi_pins_t pin_s2;
        logic rq_s1;
        logic rq_s2;
        logic rq_s3;
        logic ack_tgl;
        logic [7:0] rd_data;
        logic [7:0] threshold_config;
        logic [5:0] irq_enable;
        logic [5:0] irq_status;
        logic shutdown_latched;
        logic [3:0] pg;
        logic [3:0][FSI_PG_CNT_W-1:0] pg_cnt;
        logic shutdown_prev;
        logic [3:0] run;
        logic [3:0] soft_start;
        logic alert_oe_n;
        logic alert_o;
    } fsi_sys_t;

    typedef struct packed {
        logic scl_s1;
        logic scl_s2;
        logic scl_s3;
        logic sda_s1;
        logic sda_s2;
        logic sda_s3;
        logic asel_s1;
        logic asel_s2;
        logic ack_s1;
        logic ack_s2;
        logic ack_s3;
        fsi_lstate_t state;
        fsi_lstate_t after;
        logic [3:0] bitcnt;
        logic [7:0] shreg;
        logic [7:0] tx;
        logic [7:0] sub;
        logic [7:0] rdat;
        logic rw;
        logic acked;
        logic req_tgl;
        fsi_req_t req;
        logic sda_oe_n;
        logic sda_o;
    } fsi_link_t;

endpackage : fsi_pkg

// file: testbench/fsi_fault_irq_bench.sv
module fsi_fault_irq_bench
    import fsi_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [7:0] OH = 8'h01 << FSI_FLAG_OVERHEAT;
    localparam logic [7:0] LI = 8'h01 << FSI_FLAG_LOW_INPUT;
    localparam logic [7:0] TS = 8'h01 << FSI_SHUTDOWN_LATCHED_BIT;
    localparam logic [7:0] ST = FSI_REG_FAULT_INTERRUPT_STATUS;
    localparam logic [7:0] EN = FSI_REG_FAULT_INTERRUPT_ENABLE;
    logic clk = 1'b0, link_clk = 1'b0, rst_n = 1'b0, address_select = 1'b0;
    logic scl, sda_h, sda_o, sda_oe_n, alert_o, alert_oe_n;
    logic overheat_detect = 1'b0, channel1_supply_low = 1'b0;
    logic thermal_shutdown_detect = 1'b0;
    logic [3:0] pg_below_fail = 4'h0, pg_above_good = 4'hF;
    logic [3:0] channel_enable_inputs = 4'h0, ss_seen = 4'h0;
    logic [1:0] overheat_threshold_sel;
    logic [3:0] low_input_threshold_code, channel_run, soft_start_pulse;
    logic [3:0] channel_power_good;
    logic [6:0] dev = FSI_TARGET_ADDR;
    int fails = 0, compares = 0;
    wire logic sda = sda_h & (sda_oe_n | sda_o);

    always #50 clk = ~clk;
    initial begin
        #3.3;
        forever #7.5 link_clk = ~link_clk;
    end
    always @(posedge clk) ss_seen <= ss_seen | soft_start_pulse;

    fsi_host host (.scl(scl), .sda_h(sda_h), .sda(sda));
    fsi_fault_irq dut (
        .clk(clk), .rst_n(rst_n), .link_clk(link_clk), .scl_i(scl),
        .sda_i(sda), .sda_o(sda_o), .sda_oe_n(sda_oe_n),
        .address_select(address_select), .overheat_detect(overheat_detect),
        .channel1_supply_low(channel1_supply_low),
        .thermal_shutdown_detect(thermal_shutdown_detect),
        .pg_below_fail(pg_below_fail), .pg_above_good(pg_above_good),
        .channel_enable_inputs(channel_enable_inputs),
        .alert_o(alert_o), .alert_oe_n(alert_oe_n),
        .overheat_threshold_sel(overheat_threshold_sel),
        .low_input_threshold_code(low_input_threshold_code),
        .channel_run(channel_run), .soft_start_pulse(soft_start_pulse),
        .channel_power_good(channel_power_good)
    );

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic give_verdict;
        if (fails == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : give_verdict
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask : tick
    task automatic wr(input logic [7:0] s, d);
        host.wr(dev, s, d);
        tick(1);
    endtask : wr
    task automatic rchk(input logic [7:0] s, exp);
        logic [7:0] r;
        host.rd(dev, s, r);
        tick(1);
        chk(r, exp);
    endtask : rchk

    initial begin
        #5_000_000;
        fails++;
        give_verdict();
    end

    initial begin
        logic [7:0] v;
        tick(20);
        rst_n = 1'b1;
        tick(5);
        chk(alert_oe_n, 1'b1);
        rchk(FSI_REG_THRESHOLD_CONFIG, 8'h00);
        rchk(FSI_REG_LATCHED_FAULT_STATUS, 8'h00);
        rchk(ST, 8'h00);
        rchk(EN, 8'h00);
        rchk(8'h0A, 8'h00);
        for (int k = 0; k < 3; k++) begin
            v = 8'(17 * k + 3);
            wr(FSI_REG_THRESHOLD_CONFIG, v);
            rchk(FSI_REG_THRESHOLD_CONFIG, v);
            chk(overheat_threshold_sel, v[5:4]);
            chk(low_input_threshold_code, v[3:0]);
        end
        channel_enable_inputs = 4'hF;
        wr(EN, 8'h3F);
        rchk(EN, 8'h3F);
        chk(host.nak, 1'b0);
        overheat_detect = 1'b1;
        channel1_supply_low = 1'b1;
        tick(5);
        overheat_detect = 1'b0;
        channel1_supply_low = 1'b0;
        tick(5);
        chk({alert_o, alert_oe_n}, 2'h0);
        chk(channel_run, 4'hF);
        rchk(ST, OH | LI);
        wr(ST, 8'h00);
        rchk(ST, OH | LI);
        wr(ST, LI);
        rchk(ST, OH);
        chk(alert_oe_n, 1'b0);
        wr(ST, OH);
        chk(alert_oe_n, 1'b1);
        wr(EN, LI);
        overheat_detect = 1'b1;
        tick(5);
        overheat_detect = 1'b0;
        tick(3);
        chk(alert_oe_n, 1'b1);
        rchk(ST, OH);
        wr(EN, OH | LI);
        channel_enable_inputs = 4'h0;
        tick(8);
        channel_enable_inputs = 4'hF;
        rchk(ST, 8'h00);
        pg_below_fail = 4'h2;
        tick(300);
        pg_below_fail = 4'h0;
        tick(5);
        chk(channel_power_good, 4'hF);
        pg_below_fail = 4'h1;
        tick(520);
        chk(channel_power_good, 4'hE);
        pg_below_fail = 4'h0;
        rchk(ST, 8'h01 << FSI_FLAG_CH1_PG);
        thermal_shutdown_detect = 1'b1;
        tick(5);
        chk(channel_run, 4'h0);
        wr(FSI_REG_LATCHED_FAULT_STATUS, TS);
        rchk(FSI_REG_LATCHED_FAULT_STATUS, TS);
        channel_enable_inputs = 4'h5;
        tick(5);
        chk(channel_run, 4'h0);
        thermal_shutdown_detect = 1'b0;
        tick(6);
        chk(ss_seen, 4'h5);
        chk(channel_run, 4'h5);
        channel_enable_inputs = 4'hF;
        wr(FSI_REG_LATCHED_FAULT_STATUS, TS);
        rchk(FSI_REG_LATCHED_FAULT_STATUS, 8'h00);
        host.nak = 1'b0;
        host.wr(FSI_GENERAL_CALL, EN, 8'h3F);
        chk(host.nak, 1'b1);
        rchk(EN, OH | LI);
        address_select = 1'b1;
        host.nak = 1'b0;
        host.wr(FSI_TARGET_ADDR, EN, 8'h00);
        chk(host.nak, 1'b1);
        dev = {FSI_TARGET_ADDR[6:1], 1'b1};
        host.nak = 1'b0;
        wr(EN, 8'h21);
        rchk(EN, 8'h21);
        chk(host.nak, 1'b0);
        give_verdict();
    end
endmodule : fsi_fault_irq_bench

// file: testbench/fsi_fault_irq_chk.sv
module fsi_fault_irq_chk (
    // Clocks and reset
    input wire logic clk,
    input wire logic link_clk,
    input wire logic rst_n,
    // Watched inputs
    input wire logic scl_i,
    input wire logic overheat_detect,
    input wire logic channel1_supply_low,
    input wire logic thermal_shutdown_detect,
    input wire logic [3:0] pg_below_fail,
    input wire logic [3:0] channel_enable_inputs,
    // Watched outputs
    input wire logic sda_oe_n,
    input wire logic alert_oe_n,
    input wire logic [3:0] channel_run,
    input wire logic [3:0] soft_start_pulse,
    input wire logic [3:0] channel_power_good
);
    timeunit 1ns;
    timeprecision 100ps;

    chk_shutdown_off:
        assert property (@(posedge clk) disable iff (!rst_n)
            thermal_shutdown_detect [*5] |-> channel_run == 4'h0)
        else $error("channel running in shutdown");
    chk_run_follows:
        assert property (@(posedge clk) disable iff (!rst_n)
            (channel_enable_inputs == 4'hF && !thermal_shutdown_detect) [*8]
            |-> channel_run == 4'hF)
        else $error("enabled channel not running");
    chk_soft_enabled:
        assert property (@(posedge clk) disable iff (!rst_n)
            soft_start_pulse != 4'h0
            |-> (soft_start_pulse & ~channel_enable_inputs) == 4'h0)
        else $error("soft start on disabled channel");
    chk_alert_cleared:
        assert property (@(posedge clk) disable iff (!rst_n)
            (channel_enable_inputs == 4'h0 && !overheat_detect &&
            !channel1_supply_low && pg_below_fail == 4'h0) [*6]
            |-> alert_oe_n)
        else $error("alert held with all enables low");
    chk_alert_reset:
        assert property (@(posedge clk) disable iff (!rst_n)
            $rose(rst_n) |-> alert_oe_n [*4])
        else $error("alert driven after reset");
    // Moving SDA while SCL is high would fake a start or stop
    chk_sda_scl_low:
        assert property (@(posedge link_clk) disable iff (!rst_n)
            $changed(sda_oe_n) |-> !scl_i)
        else $error("data line moved with clock high");
    chk_pg_filter:
        assert property (@(posedge clk) disable iff (!rst_n)
            $rose(pg_below_fail[0]) ##1
            (pg_below_fail[0] throughout ##[510:510] 1'b1)
            |-> !channel_power_good[0])
        else $error("power good not dropped");
    chk_pg_hold:
        assert property (@(posedge clk) disable iff (!rst_n)
            $rose(pg_below_fail[1]) && channel_power_good[1]
            |-> channel_power_good[1] [*8])
        else $error("power good dropped early");

    cov_soft: cover property (@(posedge clk) soft_start_pulse != 4'h0);
    cov_alert: cover property (@(posedge clk) $fell(alert_oe_n));
    cov_sda: cover property (@(posedge link_clk) !sda_oe_n);
endmodule : fsi_fault_irq_chk

bind fsi_fault_irq fsi_fault_irq_chk u_chk (
    .clk(clk), .link_clk(link_clk), .rst_n(rst_n), .scl_i(scl_i),
    .overheat_detect(overheat_detect),
    .channel1_supply_low(channel1_supply_low),
    .thermal_shutdown_detect(thermal_shutdown_detect),
    .pg_below_fail(pg_below_fail),
    .channel_enable_inputs(channel_enable_inputs),
    .sda_oe_n(sda_oe_n), .alert_oe_n(alert_oe_n),
    .channel_run(channel_run), .soft_start_pulse(soft_start_pulse),
    .channel_power_good(channel_power_good)
);

// file: testbench/fsi_host.sv
module fsi_host (
    // Bus pins; sda_h high means released
    output logic scl,
    output logic sda_h,
    input wire logic sda
);
    timeunit 1ns;
    timeprecision 100ps;
    logic nak = 1'b0;

    initial begin
        scl = 1'b1;
        sda_h = 1'b1;
    end
    // 2500 ns per bit keeps the bus at 400 kHz
    task automatic bitx(input logic b, output logic r);
        sda_h = b;
        #625 scl = 1'b1;
        #625 r = sda;
        #625 scl = 1'b0;
        #625;
    endtask : bitx
    task automatic start;
        sda_h = 1'b1;
        #625 scl = 1'b1;
        #625 sda_h = 1'b0;
        #625 scl = 1'b0;
        #625;
    endtask : start
    task automatic stop;
        sda_h = 1'b0;
        #625 scl = 1'b1;
        #625 sda_h = 1'b1;
        #625;
    endtask : stop
    // Read bytes always end with a NACK
    task automatic xfer(input logic [7:0] d, input logic rd,
                        output logic [7:0] r);
        logic a;
        for (int i = 7; i >= 0; i--) bitx(d[i], r[i]);
        bitx(1'b1, a);
        if (!rd) nak = nak | a;
    endtask : xfer
    task automatic wr(input logic [6:0] a, input logic [7:0] s, d);
        logic [7:0] r;
        start();
        xfer({a, 1'b0}, 1'b0, r);
        xfer(s, 1'b0, r);
        xfer(d, 1'b0, r);
        stop();
    endtask : wr
    task automatic rd(input logic [6:0] a, input logic [7:0] s,
                      output logic [7:0] d);
        logic [7:0] r;
        start();
        xfer({a, 1'b0}, 1'b0, r);
        xfer(s, 1'b0, r);
        start();
        xfer({a, 1'b1}, 1'b0, r);
        xfer(8'hFF, 1'b1, d);
        stop();
    endtask : rd
endmodule : fsi_host
